// >>> hdl/ebwrh_pkg.sv
// Constants and types for the external write, ready and hold interface
package ebwrh_pkg;
	localparam int ADDR_W = 19;
	localparam int DATA_W = 16;
	localparam int REG_AW = 8;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_TIMING = 8'h04;
	localparam logic [7:0] OFS_ADDR = 8'h08;
	localparam logic [7:0] OFS_WDATA = 8'h0c;
	localparam logic [7:0] OFS_GO = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	// Control fields
	localparam int CTRL_HOLD_MODE = 0;
	localparam int CTRL_USE_RDY = 1;
	localparam int CTRL_ASYNC = 2;
	localparam int CTRL_DBL = 3;
	localparam logic [3:0] CTRL_RST = 4'h0;
	// Timing fields: lead [1:0], active [4:2], trail [6:5]
	localparam int TIM_LEAD_LSB = 0;
	localparam int TIM_ACT_LSB = 2;
	localparam int TIM_TRAIL_LSB = 5;
	localparam logic [6:0] TIM_RST = 7'h7f;
	// Status fields
	localparam int STAT_BUSY = 0;
	localparam int STAT_GRANT = 1;
	localparam int STAT_STALL = 2;
	// Asynchronous ready samples this many timing cycles early
	localparam logic [4:0] ASYNC_EARLY = 5'h02;
	// Hold handshake limits in timing cycles
	localparam int HOLD_ACK_MAX = 5;
	localparam int HOLD_REL_MAX = 3;
	// Zone select codes
	localparam logic [1:0] ZONE_LOW = 2'h0;
	localparam logic [1:0] ZONE_MID = 2'h1;
	localparam logic [1:0] ZONE_HIGH = 2'h2;

	typedef enum logic [1:0] {S_IDLE, S_ALIGN, S_BUSY, S_HELD} ebwrh_state_t;

	typedef struct packed {
		logic use_rdy;
		logic async;
		logic [1:0] lead;
		logic [2:0] active;
		logic [1:0] trail;
	} ebwrh_cfg_t;

	typedef struct packed {
		ebwrh_cfg_t cfg;
		logic [1:0] zone;
		logic [18:0] addr;
		logic [15:0] data;
	} ebwrh_cmd_t;
endpackage

// >>> hdl/ebwrh_top.sv
// External memory write sequencer with ready stretching and bus hold
`timescale 1ns/1ps
//
// Function
// - Ready high at first sample ends access
// - Ready low: resample every timing cycle
// - Sync sample at lead+active; async two earlier
// - Lead phase starts on bus clock rise
// - Alignment cycle keeps strobes inactive
// - Address bus holds last value when idle
// - Hold mode set releases grant, resumes driving
// - Reset clears hold mode bit
// - Reset: bus floated, hold acknowledge low
// - Internal execution continues during grant
// - External access stalls while bus granted
// - Grant floats address, data, strobes, selects
// - Other interface pins keep normal function
// - Hold request captured on timing clock
// - Access in progress completes before floating; grant beats a pending start
// - Acknowledge within 5, release within 3
module ebwrh_top (
	input wire logic ref_clk, // Register side clock
	input wire logic rstn, // Asynchronous reset, active low
	input wire logic [7:0] reg_addr, // Register byte address
	input wire logic [31:0] reg_wdata, // Register write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [31:0] reg_rdata, // Read data, cycle after strobe
	output logic cpu_stall, // External access stalled by grant
	input wire logic iface_timing_clk, // Interface timing clock
	input wire logic ext_ready_in, // External ready pin
	input wire logic bus_hold_req_n, // Hold request pin
	output logic bus_hold_ack_n, // Hold acknowledge pin
	output logic bus_clock_out, // Bus clock pin
	output logic [18:0] ext_addr_bus_o, // Address pins
	output logic ext_addr_bus_oe, // Address enable
	output logic [15:0] ext_data_bus_o, // Data pins
	output logic ext_data_bus_oe, // Data enable
	output logic write_strobe_n, // Write strobe pin
	output logic read_strobe_n, // Read strobe pin
	output logic read_not_write, // Direction pin
	output logic zone_sel_low_pair_n, // Zone select, low pair
	output logic zone_sel_mid_n, // Zone select, middle
	output logic zone_sel_high_pair_n, // Zone select, high pair
	output logic ctrl_oe // Enable for strobes and selects
);

	function automatic logic [4:0] act_end(input ebwrh_pkg::ebwrh_cfg_t c);
		act_end = 5'(c.lead) + 5'(c.active);
	endfunction

	// first sample point, async two earlier
	function automatic logic [4:0] samp_idx(input ebwrh_pkg::ebwrh_cfg_t c);
		logic [4:0] off;
		off = c.async ? ebwrh_pkg::ASYNC_EARLY + 5'h01 : 5'h01;
		samp_idx = (act_end(c) >= off) ? act_end(c) - off : 5'h00;
	endfunction

	function automatic logic [4:0] end_idx(input ebwrh_pkg::ebwrh_cfg_t c);
		logic [4:0] tot;
		tot = act_end(c) + 5'(c.trail);
		end_idx = (tot != 5'h00) ? tot - 5'h01 : 5'h00;
	endfunction

	// Register side
	logic [3:0] ctrl;
	logic [6:0] timing;
	logic [18:0] addr_r;
	logic [15:0] wdata_r;
	ebwrh_pkg::ebwrh_cmd_t cmd;
	logic go_tgl;
	logic dn1, done_s;
	logic gr1, granted_s;

	// Link side
	logic lrst1, lrst_n;
	logic hreq1, hreq_s;
	logic rdy1, rdy_s;
	logic [1:0] cfg1, cfg_s;
	logic go1, go_s;
	logic taken, done_tgl;
	logic clk_half, held_q;
	ebwrh_pkg::ebwrh_state_t st, next_st;
	logic [4:0] el, next_el;
	logic [18:0] addr_q;
	logic [15:0] data_q;

	wire busy = go_tgl != done_s;
	wire wr_ctrl = reg_wr && reg_addr == ebwrh_pkg::OFS_CTRL;
	wire wr_tim = reg_wr && reg_addr == ebwrh_pkg::OFS_TIMING;
	wire wr_addr = reg_wr && reg_addr == ebwrh_pkg::OFS_ADDR;
	wire wr_data = reg_wr && reg_addr == ebwrh_pkg::OFS_WDATA;
	// Start refused while a write is still in flight
	wire go_ok = reg_wr && reg_addr == ebwrh_pkg::OFS_GO && !busy;

	wire ebwrh_pkg::ebwrh_cfg_t next_cfg = '{
		use_rdy: ctrl[ebwrh_pkg::CTRL_USE_RDY],
		async: ctrl[ebwrh_pkg::CTRL_ASYNC],
		lead: timing[ebwrh_pkg::TIM_LEAD_LSB +: 2],
		active: timing[ebwrh_pkg::TIM_ACT_LSB +: 3],
		trail: timing[ebwrh_pkg::TIM_TRAIL_LSB +: 2]
	};
	wire ebwrh_pkg::ebwrh_cmd_t next_cmd = '{
		cfg: next_cfg,
		zone: reg_wdata[1:0],
		addr: addr_r,
		data: wdata_r
	};

	wire [31:0] status = {29'h0, cpu_stall, granted_s, busy};
	wire [31:0] rd_word =
		(reg_addr == ebwrh_pkg::OFS_CTRL) ? {28'h0, ctrl} :
		(reg_addr == ebwrh_pkg::OFS_TIMING) ? {25'h0, timing} :
		(reg_addr == ebwrh_pkg::OFS_ADDR) ? {13'h0, addr_r} :
		(reg_addr == ebwrh_pkg::OFS_WDATA) ? {16'h0, wdata_r} :
		(reg_addr == ebwrh_pkg::OFS_STATUS) ? status : 32'h0;

	assign cpu_stall = busy && granted_s;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl <= ebwrh_pkg::CTRL_RST;
			timing <= ebwrh_pkg::TIM_RST;
			addr_r <= 19'h0;
			wdata_r <= 16'h0;
		end else begin
			if (wr_ctrl)
				ctrl <= reg_wdata[3:0];
			if (wr_tim)
				timing <= reg_wdata[6:0];
			if (wr_addr)
				addr_r <= reg_wdata[18:0];
			if (wr_data)
				wdata_r <= reg_wdata[15:0];
		end
	end

	// Command held stable until the link hands back completion
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cmd <= '0;
			go_tgl <= 1'b0;
		end else if (go_ok) begin
			cmd <= next_cmd;
			go_tgl <= ~go_tgl;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			dn1 <= 1'b0;
			done_s <= 1'b0;
			gr1 <= 1'b1;
			granted_s <= 1'b1;
			reg_rdata <= 32'h0;
		end else begin
			dn1 <= done_tgl;
			done_s <= dn1;
			// Registered flag, a decoded state could glitch in flight
			gr1 <= held_q;
			granted_s <= gr1;
			reg_rdata <= reg_rd ? rd_word : 32'h0;
		end
	end

	// Link reset: asserted at once, released on the timing clock
	always_ff @(posedge iface_timing_clk or negedge rstn) begin
		if (!rstn) begin
			lrst1 <= 1'b0;
			lrst_n <= 1'b0;
		end else begin
			lrst1 <= 1'b1;
			lrst_n <= lrst1;
		end
	end

	always_ff @(posedge iface_timing_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			hreq1 <= 1'b0;
			hreq_s <= 1'b0;
			rdy1 <= 1'b0;
			rdy_s <= 1'b0;
			cfg1 <= 2'h0;
			cfg_s <= 2'h0;
			go1 <= 1'b0;
			go_s <= 1'b0;
		end else begin
			hreq1 <= bus_hold_req_n;
			hreq_s <= hreq1;
			rdy1 <= ext_ready_in;
			rdy_s <= rdy1;
			cfg1 <= {ctrl[ebwrh_pkg::CTRL_DBL], ctrl[ebwrh_pkg::CTRL_HOLD_MODE]};
			cfg_s <= cfg1;
			go1 <= go_tgl;
			go_s <= go1;
		end
	end

	wire hm_s = cfg_s[0];
	wire dbl_s = cfg_s[1];
	wire pending = go_s != taken;
	wire [4:0] la = act_end(cmd.cfg);
	wire [4:0] sidx = samp_idx(cmd.cfg);
	wire [4:0] eidx = end_idx(cmd.cfg);

	wire at_sample = st == ebwrh_pkg::S_BUSY && cmd.cfg.use_rdy && el == sidx;
	wire stretch = at_sample && !rdy_s;
	// ready high lets the access run out
	wire last = st == ebwrh_pkg::S_BUSY && el == eidx && !stretch;
	// grant three edges after the pin
	// grant only while hold mode is clear
	wire grant = st == ebwrh_pkg::S_IDLE && !hreq_s && !hm_s;
	wire start = st == ebwrh_pkg::S_IDLE && !grant && pending;
	// next edge is a bus clock rise
	wire aligned = !dbl_s || !clk_half;
	wire go_busy = next_st == ebwrh_pkg::S_BUSY && st != ebwrh_pkg::S_BUSY;
	wire in_active = st == ebwrh_pkg::S_BUSY && el >= 5'(cmd.cfg.lead) && el < la;
	wire on_bus = st == ebwrh_pkg::S_BUSY;

	always_comb begin
		next_st = st;
		case (st)
			ebwrh_pkg::S_IDLE: begin
				if (grant)
					next_st = ebwrh_pkg::S_HELD;
				else if (start)
					next_st = aligned ? ebwrh_pkg::S_BUSY : ebwrh_pkg::S_ALIGN;
			end
			ebwrh_pkg::S_ALIGN:
				next_st = ebwrh_pkg::S_BUSY;
			ebwrh_pkg::S_BUSY:
				if (last)
					next_st = ebwrh_pkg::S_IDLE;
			ebwrh_pkg::S_HELD: begin
				if (hreq_s || hm_s)
					next_st = ebwrh_pkg::S_IDLE;
			end
			default:
				next_st = ebwrh_pkg::S_IDLE;
		endcase
	end

	assign next_el = (on_bus && next_st == ebwrh_pkg::S_BUSY) ? (stretch ? el : el + 5'h01) : 5'h00;

	always_ff @(posedge iface_timing_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			st <= ebwrh_pkg::S_HELD;
			el <= 5'h00;
			clk_half <= 1'b0;
			held_q <= 1'b1;
		end else begin
			st <= next_st;
			el <= next_el;
			clk_half <= ~clk_half;
			held_q <= next_st == ebwrh_pkg::S_HELD;
		end
	end

	// address loads only at access start
	always_ff @(posedge iface_timing_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			addr_q <= 19'h0;
			data_q <= 16'h0;
			taken <= 1'b0;
			done_tgl <= 1'b0;
		end else begin
			if (go_busy) begin
				addr_q <= cmd.addr;
				data_q <= cmd.data;
			end
			if (start)
				taken <= go_s;
			if (last)
				done_tgl <= taken;
		end
	end

	assign bus_clock_out = dbl_s ? clk_half : iface_timing_clk;
	assign bus_hold_ack_n = st != ebwrh_pkg::S_HELD;
	assign ext_addr_bus_oe = st != ebwrh_pkg::S_HELD;
	assign ctrl_oe = st != ebwrh_pkg::S_HELD;
	assign ext_data_bus_oe = on_bus;
	assign ext_addr_bus_o = addr_q;
	assign ext_data_bus_o = data_q;
	assign write_strobe_n = !in_active;
	assign read_strobe_n = 1'b1;
	assign read_not_write = !on_bus;
	assign zone_sel_low_pair_n = !(on_bus && cmd.zone == ebwrh_pkg::ZONE_LOW);
	assign zone_sel_mid_n = !(on_bus && cmd.zone == ebwrh_pkg::ZONE_MID);
	assign zone_sel_high_pair_n = !(on_bus && cmd.zone == ebwrh_pkg::ZONE_HIGH);

	a_ready_finish: assert property (
		@(posedge iface_timing_clk) disable iff (!lrst_n)
		(at_sample && rdy_s) |=> (el == $past(el) + 5'h01 || st == ebwrh_pkg::S_IDLE)
	) else $error("access did not advance after ready high");

	a_ready_stretch: assert property (
		@(posedge iface_timing_clk) disable iff (!lrst_n)
		(at_sample && !rdy_s) |=> (st == ebwrh_pkg::S_BUSY && el == $past(el) && at_sample)
	) else $error("access not held while ready low");

	a_sample_sync: assert property (
		@(posedge iface_timing_clk) disable iff (!lrst_n)
		(at_sample && !cmd.cfg.async && la != 5'h00) |-> (el + 5'h01 == la)
	) else $error("sync ready sampled at wrong cycle");

	a_sample_async: assert property (
		@(posedge iface_timing_clk) disable iff (!lrst_n)
		(at_sample && cmd.cfg.async && la >= 5'h03) |-> (el + 5'h03 == la)
	) else $error("async ready sampled at wrong cycle");

	a_align_edge: assert property (
		@(posedge iface_timing_clk) disable iff (!lrst_n)
		(on_bus && $past(st) != ebwrh_pkg::S_BUSY && dbl_s && $past(dbl_s)) |-> clk_half
	) else $error("access lead not on bus clock rise");

	a_align_quiet: assert property (
		@(posedge iface_timing_clk) disable iff (!lrst_n)
		(st == ebwrh_pkg::S_ALIGN) |-> (write_strobe_n && read_not_write && zone_sel_low_pair_n
			&& zone_sel_mid_n && zone_sel_high_pair_n && !ext_data_bus_oe)
	) else $error("strobe active in alignment cycle");

	a_addr_hold: assert property (
		@(posedge iface_timing_clk) disable iff (!lrst_n)
		(!on_bus && !go_busy) |=> $stable(ext_addr_bus_o)
	) else $error("address changed while inactive");

	a_hold_float: assert property (
		@(posedge iface_timing_clk) disable iff (!lrst_n)
		(st == ebwrh_pkg::S_HELD) |-> (!ext_addr_bus_oe && !ext_data_bus_oe && !ctrl_oe && !bus_hold_ack_n)
	) else $error("pins driven during grant");

	a_hold_mode_exit: assert property (
		@(posedge iface_timing_clk) disable iff (!lrst_n)
		(st == ebwrh_pkg::S_HELD && hm_s) |=> (bus_hold_ack_n && ctrl_oe ##1 bus_hold_ack_n)
	) else $error("hold mode did not end grant");

	a_hold_grant: assert property (
		@(posedge iface_timing_clk) disable iff (!lrst_n)
		(st == ebwrh_pkg::S_IDLE && !hreq_s && !hm_s) |=> !bus_hold_ack_n
	) else $error("idle bus not granted on request");

	a_hold_release: assert property (
		@(posedge iface_timing_clk) disable iff (!lrst_n)
		($rose(hreq_s) && st == ebwrh_pkg::S_HELD) |=> (bus_hold_ack_n && ext_addr_bus_oe)
	) else $error("acknowledge not released");
endmodule

// >>> verification/ebwrh_far.sv
// Far side: write memory with ready wait states and a bus hold requester
`timescale 1ns/1ps
module ebwrh_far (
	input wire logic tclk, // Timing clock
	input wire logic rstn, // Reset, active low
	input wire logic [18:0] addr, // Address pins
	input wire logic [15:0] data, // Data pins
	input wire logic addr_oe, // Address enable
	input wire logic we_n, // Write strobe pin
	input wire logic [2:0] zsel_n, // Selects, high to low pair
	input wire logic hold_on, // Bench wants the bus
	input wire logic [7:0] waits, // Ready wait cycles
	output logic ready, // Ready pin
	output logic hold_req_n, // Hold request pin
	output logic [37:0] cap, // Selects, address, data of last write
	output logic [7:0] stb_len, // Last strobe length
	output logic [7:0] float_err // Floats seen mid access
);
	logic [7:0] cnt;
	logic [7:0] run;
	wire sel = ~&zsel_n;
	assign ready = ~sel | (cnt >= waits);
	always_ff @(posedge tclk or negedge rstn) begin
		if (!rstn) begin
			cnt <= 8'h00;
			run <= 8'h00;
			stb_len <= 8'h00;
			float_err <= 8'h00;
			cap <= '0;
			hold_req_n <= 1'b1;
		end else begin
			hold_req_n <= ~hold_on;
			cnt <= sel ? cnt + 8'h01 : 8'h00;
			run <= we_n ? 8'h00 : run + 8'h01;
			if (!we_n)
				cap <= {~zsel_n, addr, data};
			if (we_n && run != 8'h00)
				stb_len <= run;
			if (sel && !addr_oe)
				float_err <= float_err + 8'h01;
		end
	end
endmodule

// >>> verification/testbench.sv
// Self-checking bench for the external write sequencer
`timescale 1ns/1ps
module testbench;
	logic ref_clk = 1'b0;
	logic tclk = 1'b0;
	logic rstn = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic hold_on = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] waits = 8'h00;
	logic [31:0] reg_wdata = 32'h00000000;
	logic [31:0] reg_rdata, s;
	logic stall, ack_n, clk_out, addr_oe, data_oe, we_n, rd_n, rnw, zl_n, zm_n, zh_n, ctrl_oe, ready, req_n;
	logic [18:0] addr_o;
	logic [15:0] data_o;
	logic [37:0] cap;
	logic [37:0] q[$];
	logic [7:0] stb_len, float_err;
	int err_count = 0;
	int compares = 0;
	int cyc = 0;
	int n;
	wire [2:0] zsel_n = ctrl_oe ? {zh_n, zm_n, zl_n} : 3'h7;
	always #5 ref_clk = ~ref_clk;
	// Phase unrelated to the register clock
	initial begin
		#7;
		forever #24 tclk = ~tclk;
	end
	ebwrh_top uut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_stall(stall), .iface_timing_clk(tclk), .ext_ready_in(ready),
		.bus_hold_req_n(req_n), .bus_hold_ack_n(ack_n), .bus_clock_out(clk_out), .ext_addr_bus_o(addr_o),
		.ext_addr_bus_oe(addr_oe), .ext_data_bus_o(data_o), .ext_data_bus_oe(data_oe), .write_strobe_n(we_n),
		.read_strobe_n(rd_n), .read_not_write(rnw), .zone_sel_low_pair_n(zl_n), .zone_sel_mid_n(zm_n),
		.zone_sel_high_pair_n(zh_n), .ctrl_oe(ctrl_oe));
	ebwrh_far far (.tclk(tclk), .rstn(rstn), .addr(addr_oe ? addr_o : ~addr_o), .data(data_oe ? data_o : ~data_o),
		.addr_oe(addr_oe), .we_n(ctrl_oe ? we_n : 1'b1), .zsel_n(zsel_n), .hold_on(hold_on), .waits(waits),
		.ready(ready), .hold_req_n(req_n), .cap(cap), .stb_len(stb_len), .float_err(float_err));
	task automatic end_sim;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk_word(input logic [37:0] got, input logic [37:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask
	task automatic start_wr(input logic [1:0] z, input logic [18:0] a, input logic [15:0] d);
		q.push_back({3'h1 << z, a, d});
		wr(ebwrh_pkg::OFS_ADDR, {13'h0, a});
		wr(ebwrh_pkg::OFS_WDATA, {16'h0, d});
		wr(ebwrh_pkg::OFS_GO, {30'h0, z});
	endtask
	task automatic finish_wr;
		logic [37:0] e;
		n = 0;
		s = 32'h00000001;
		while (s[ebwrh_pkg::STAT_BUSY] === 1'b1 && n < 300) begin
			rd(ebwrh_pkg::OFS_STATUS, s);
			n++;
		end
		e = q.pop_front();
		chk_flag(s[ebwrh_pkg::STAT_BUSY], 1'b0);
		chk_word(cap, e);
		chk_word({19'h0, addr_o}, {19'h0, e[34:16]});
	endtask
	task automatic one(input logic [3:0] c, input logic [1:0] ld, input logic [2:0] ac, input logic [7:0] w,
		input logic [1:0] z);
		wr(ebwrh_pkg::OFS_CTRL, {28'h0, c});
		wr(ebwrh_pkg::OFS_TIMING, {25'h0, 2'h1, ac, ld});
		waits <= w;
		start_wr(z, 19'($urandom), 16'($urandom));
		finish_wr();
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			end_sim();
		end
	end
	initial begin
		logic [2:0] ac;
		void'($urandom(66));
		repeat (16) @(posedge ref_clk);
		chk_flag(ack_n, 1'b0);
		chk_flag(addr_oe | data_oe | ctrl_oe, 1'b0);
		rstn <= 1'b1;
		repeat (8) @(posedge tclk);
		chk_flag(ack_n & ctrl_oe, 1'b1);
		rd(ebwrh_pkg::OFS_CTRL, s);
		chk_word({6'h0, s}, 38'h0);
		rd(ebwrh_pkg::OFS_TIMING, s);
		chk_word({6'h0, s}, 38'h7f);
		rd(8'h40, s);
		chk_word({6'h0, s}, 38'h0);
		// Ready ignored when sampling is off, random lead, active, waits and zone
		for (int i = 0; i < 6; i++) begin
			ac = 3'($urandom_range(7, 1));
			one(4'h0, 2'($urandom_range(3, 1)), ac, 8'($urandom_range(15, 0)), 2'($urandom_range(2, 0)));
			chk_word({30'h0, stb_len}, {35'h0, ac});
		end
		// Waits of 3 stretch only the early sampling mode
		for (int m = 0; m < 2; m++) begin
			one(m ? 4'h6 : 4'h2, 2'h2, 3'h5, 8'h03, 2'(m));
			chk_flag(stb_len == 8'h05, m == 0);
			one(m ? 4'h6 : 4'h2, 2'h2, 3'h5, 8'h00, 2'h2);
			chk_word({30'h0, stb_len}, 38'h5);
			one(m ? 4'h6 : 4'h2, 2'h2, 3'h5, 8'h0c, 2'h1);
			chk_flag(stb_len > 8'h05 && stb_len < 8'h11, 1'b1);
		end
		// Halved bus clock: lead must open on its rising edge
		for (int i = 0; i < 3; i++) begin
			wr(ebwrh_pkg::OFS_CTRL, 32'h00000008);
			wr(ebwrh_pkg::OFS_TIMING, {25'h0, 2'h1, 3'h2, 2'h1});
			waits <= 8'h00;
			start_wr(2'h0, 19'($urandom), 16'($urandom));
			@(negedge zsel_n[0]);
			#1;
			chk_flag(clk_out, 1'b1);
			chk_flag(rnw, 1'b0);
			chk_flag(rd_n, 1'b1);
			finish_wr();
			chk_word({30'h0, stb_len}, 38'h2);
		end
		one(4'h2, 2'h1, 3'h3, 8'h00, 2'h1);
		hold_on <= 1'b1;
		@(negedge req_n);
		n = 0;
		while (ack_n !== 1'b0 && n < 8) begin
			@(posedge tclk);
			#1;
			n++;
		end
		chk_flag(n <= ebwrh_pkg::HOLD_ACK_MAX, 1'b1);
		chk_flag(addr_oe | data_oe | ctrl_oe, 1'b0);
		@(posedge tclk);
		#1 chk_flag(clk_out, 1'b1);
		@(negedge tclk);
		#1 chk_flag(clk_out, 1'b0);
		rd(ebwrh_pkg::OFS_CTRL, s);
		chk_word({6'h0, s}, 38'h2);
		start_wr(2'h2, 19'h5a5a5, 16'hc3c3);
		repeat (6) @(posedge tclk);
		chk_flag(stall, 1'b1);
		chk_flag(addr_oe, 1'b0);
		hold_on <= 1'b0;
		@(posedge req_n);
		n = 0;
		while (ack_n !== 1'b1 && n < 8) begin
			@(posedge tclk);
			#1;
			n++;
		end
		chk_flag(n <= ebwrh_pkg::HOLD_REL_MAX, 1'b1);
		finish_wr();
		chk_flag(stall, 1'b0);
		// Grant asked for in mid access
		one(4'h2, 2'h1, 3'h3, 8'h08, 2'h0);
		start_wr(2'h0, 19'h00001, 16'hffff);
		@(negedge zsel_n[0]);
		@(posedge ref_clk);
		hold_on <= 1'b1;
		finish_wr();
		repeat (8) @(posedge tclk);
		chk_word({30'h0, float_err}, 38'h0);
		chk_flag(ack_n, 1'b0);
		wr(ebwrh_pkg::OFS_CTRL, 32'h00000003);
		// Hold mode bit crosses two flops before the state sees it
		repeat (4) @(posedge tclk);
		#1;
		chk_flag(ack_n, 1'b1);
		chk_flag(ctrl_oe, 1'b1);
		hold_on <= 1'b0;
		end_sim();
	end
endmodule
